/* File: include/spi_shift_pkg.sv */
// Types and constants shared by the serial shift port files
package spi_shift_pkg;
  localparam logic [2:0] OFS_MODE = 3'h0;
  localparam logic [2:0] OFS_TX = 3'h1;
  localparam logic [2:0] OFS_RX = 3'h2;
  localparam logic [2:0] OFS_STAT = 3'h3;
  localparam logic [2:0] OFS_DIV = 3'h4;
  localparam logic [15:0] MODE_RST = 16'h0007;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [3:0] LEN_MIN = 4'h3;
  localparam logic [15:0] IDLE_FILL = 16'hFFFF;
  localparam int ST_TXFULL = 0;
  localparam int ST_RXFULL = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_OVR = 3;
  localparam int ST_MME = 4;
  // Clock rate and the shortest half period of the shift clock in each role
  localparam int SYS_CLK_HZ = 40000000;
  localparam int MASTER_HALF_CYC = 2;
  localparam int SLAVE_HALF_CYC = 1;
  localparam int MASTER_SCLK_MAX_HZ = SYS_CLK_HZ / (2 * MASTER_HALF_CYC);
  localparam int SLAVE_SCLK_MAX_HZ = SYS_CLK_HZ / (2 * SLAVE_HALF_CYC);

  typedef enum logic [0:0] {S_IDLE = 1'b0, S_SHIFT = 1'b1} fsm_t;

  // Layout of port_mode_control_reg
  typedef struct packed {
    logic rsv15;
    logic loopBack;
    logic clockIdleLevelBit;
    logic clockPhase;
    logic openDrain;
    logic rsv10;
    logic master;
    logic enable;
    logic contMode;
    logic [2:0] rsv;
    logic [3:0] charLen;
  } mode_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wrData;
    logic wrStb;
    logic rdStb;
  } bus_req_t;

  typedef struct packed {
    logic serialShiftClock;
    logic masterOutSlaveInLine;
    logic masterInSlaveOutLine;
    logic slaveSelectInputN;
  } pin_in_t;

  typedef struct packed {
    logic sclkO;
    logic sclkOe;
    logic mosiO;
    logic mosiOe;
    logic misoO;
    logic misoOe;
    logic selOutN;
  } pin_out_t;

  typedef struct packed {
    logic srcPrev;
    logic [7:0] cnt;
    logic tick;
  } baud_t;
endpackage

/* File: hw/spi_baud_gen.sv */
// Baud rate generator: divides the baud source clock into shift clock half periods
`timescale 1ns/1ps
module spi_baud_gen
  import spi_shift_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstN,
  input wire logic run,
  input wire logic baudSourceClock,
  input wire logic [7:0] ratio,
  output logic tick
);
  baud_t r;
  baud_t next_r;

  always_comb begin
    next_r = r;
    next_r.srcPrev = baudSourceClock;
    next_r.tick = 1'b0;
    if (!run) begin
      next_r.cnt = 8'h00;
    end else if (baudSourceClock && !r.srcPrev) begin
      // One half period every ratio+1 source rising edges
      if (r.cnt == ratio) begin
        next_r.cnt = 8'h00;
        next_r.tick = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule

/* File: hw/spi_shift_core.sv */
// Serial shift port core: registers, shift engine, pin control
`timescale 1ns/1ps
module spi_shift_core
  import spi_shift_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input spi_shift_pkg::bus_req_t bus,
  output logic [15:0] rdData,
  input spi_shift_pkg::pin_in_t pinIn,
  output spi_shift_pkg::pin_out_t pinOut,
  input wire logic baudSourceClock,
  output logic multiMasterError
);
  import spi_shift_pkg::*;

  typedef struct packed {
    mode_t mode;
    logic [7:0] div;
    logic [15:0] txHold;
    logic txFull;
    logic [15:0] rxHold;
    logic rxFull;
    logic ovr;
    logic mme;
    fsm_t fsm;
    logic [15:0] sh;
    logic [15:0] lastTx;
    logic [3:0] cnt;
    logic smp;
    logic outBit;
    logic sclk;
    logic sclkPrev;
    pin_out_t pins;
    logic [15:0] rdData;
  } core_t;

  core_t r;
  core_t next_r;
  logic [1:0] rstPipe;
  logic rstN;
  logic baudTick;
  logic baudRun;
  logic charDone;

  function automatic logic [3:0] effLen(input logic [3:0] code);
    effLen = (code < LEN_MIN) ? LEN_MIN : code;
  endfunction

  function automatic logic [15:0] lenMask(input logic [3:0] len);
    lenMask = IDLE_FILL >> (4'hF - len);
  endfunction

  function automatic logic odEnable(input logic drive, input logic od, input logic val);
    odEnable = drive && (!od || !val);
  endfunction

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  // Generator only runs while a master character is on the wire
  assign baudRun = r.mode.enable && r.mode.master && !r.mme && r.fsm == S_SHIFT;

  spi_baud_gen baudGen (
    .sys_clk(sys_clk),
    .rstN(rstN),
    .run(baudRun),
    .baudSourceClock(baudSourceClock),
    .ratio(r.div),
    .tick(baudTick)
  );

  always_comb begin
    logic master;
    logic active;
    logic inBit;
    logic edgeNow;
    logic lead;
    logic doLoad;
    logic [3:0] len;
    logic [15:0] ld;
    logic [15:0] rxWord;
    next_r = r;
    charDone = 1'b0;
    doLoad = 1'b0;
    ld = IDLE_FILL;
    rxWord = 16'h0000;
    edgeNow = 1'b0;
    lead = 1'b0;
    master = r.mode.master;
    active = r.mode.enable && !r.mme;
    len = effLen(r.mode.charLen);
    next_r.rdData = 16'h0000;
    next_r.sclkPrev = pinIn.serialShiftClock;

    // Register port first, so that hardware sets below win over clears
    if (bus.wrStb) begin
      case (bus.addr)
        OFS_MODE: next_r.mode = mode_t'(bus.wrData);
        OFS_TX: begin
          if (!r.txFull) begin
            next_r.txHold = bus.wrData;
            next_r.txFull = 1'b1;
          end
        end
        OFS_STAT: begin
          if (bus.wrData[ST_OVR]) next_r.ovr = 1'b0;
          if (bus.wrData[ST_MME]) next_r.mme = 1'b0;
        end
        OFS_DIV: next_r.div = bus.wrData[7:0];
        default: ;
      endcase
    end
    if (bus.rdStb) begin
      case (bus.addr)
        OFS_MODE: next_r.rdData = r.mode;
        OFS_TX: next_r.rdData = r.txHold;
        OFS_RX: begin
          next_r.rdData = r.rxHold;
          next_r.rxFull = 1'b0;
        end
        OFS_STAT: next_r.rdData = {11'h000, r.mme, r.ovr, r.fsm == S_SHIFT, r.rxFull, r.txFull};
        OFS_DIV: next_r.rdData = {8'h00, r.div};
        default: next_r.rdData = 16'h0000;
      endcase
    end

    // Receive source: far line, or our own driven bit in loopback
    inBit = r.mode.loopBack ? r.outBit :
            (master ? pinIn.masterInSlaveOutLine : pinIn.masterOutSlaveInLine);

    // Shift edges: baud ticks as master, gated far clock as slave
    if (master) begin
      edgeNow = baudTick;
      lead = (r.sclk == r.mode.clockIdleLevelBit);
    end else begin
      edgeNow = (pinIn.serialShiftClock != r.sclkPrev) && !pinIn.slaveSelectInputN;
      lead = (r.sclkPrev == r.mode.clockIdleLevelBit);
    end

    case (r.fsm)
      S_IDLE: begin
        next_r.sclk = r.mode.clockIdleLevelBit;
        doLoad = active && (master ? (r.txFull || r.mode.contMode)
                                   : !pinIn.slaveSelectInputN);
      end
      S_SHIFT: begin
        if (!master && pinIn.slaveSelectInputN) begin
          next_r.fsm = S_IDLE;
        end else if (edgeNow) begin
          if (master) next_r.sclk = !r.sclk;
          if (lead) begin
            // Phase 0 samples on the leading edge, phase 1 drives on it
            if (!r.mode.clockPhase) next_r.smp = inBit;
            else next_r.outBit = r.sh[15];
          end else begin
            // In phase 0 out and in move together on the trailing edge; in phase 1 only the sampled bit shifts in here
            next_r.sh = {r.sh[14:0], r.mode.clockPhase ? inBit : r.smp};
            if (!r.mode.clockPhase) next_r.outBit = r.sh[14];
            if (r.cnt == 4'h0) begin
              charDone = 1'b1;
              rxWord = next_r.sh & lenMask(len);
              if (r.rxFull && !(bus.rdStb && bus.addr == OFS_RX)) begin
                next_r.ovr = 1'b1;
              end else begin
                next_r.rxHold = rxWord;
                next_r.rxFull = 1'b1;
              end
              // Next character follows with no gap when one is ready
              doLoad = active && (master ? (r.txFull || r.mode.contMode)
                                         : !pinIn.slaveSelectInputN);
              if (!doLoad) next_r.fsm = S_IDLE;
            end else begin
              next_r.cnt = r.cnt - 4'h1;
            end
          end
        end
      end
      default: next_r.fsm = S_IDLE;
    endcase

    if (doLoad) begin
      // Slave with nothing queued sends ones unless repeating
      if (r.txFull) ld = r.txHold;
      else if (master || r.mode.contMode) ld = r.lastTx;
      else ld = IDLE_FILL;
      next_r.fsm = S_SHIFT;
      next_r.cnt = len;
      next_r.lastTx = ld;
      next_r.sh = ld << (4'hF - len);
      next_r.outBit = next_r.sh[15];
      // Only a consumed word empties the holding register; a write landing now stays
      if (r.txFull) next_r.txFull = 1'b0;
      next_r.sclk = r.mode.clockIdleLevelBit;
    end

    // Another master pulled our select low: stop and let go of the lines
    if (r.mode.enable && master && !pinIn.slaveSelectInputN) begin
      next_r.mme = 1'b1;
    end
    if (!(next_r.mode.enable && !next_r.mme)) begin
      next_r.fsm = S_IDLE;
      next_r.sclk = next_r.mode.clockIdleLevelBit;
    end

    // Pin drivers follow the settled next state; open drain only pulls low
    active = next_r.mode.enable && !next_r.mme;
    master = next_r.mode.master;
    next_r.pins.sclkO = next_r.sclk && !next_r.mode.openDrain;
    next_r.pins.sclkOe = odEnable(active && master, next_r.mode.openDrain, next_r.sclk);
    next_r.pins.mosiO = next_r.outBit && !next_r.mode.openDrain;
    next_r.pins.mosiOe = odEnable(active && master, next_r.mode.openDrain,
                                  next_r.outBit);
    next_r.pins.misoO = next_r.outBit && !next_r.mode.openDrain;
    next_r.pins.misoOe = odEnable(active && !master && !pinIn.slaveSelectInputN,
                                  next_r.mode.openDrain, next_r.outBit);
    next_r.pins.selOutN = !(active && master && next_r.fsm == S_SHIFT);
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      r <= '0;
      r.mode <= mode_t'(MODE_RST);
      r.div <= DIV_RST;
      r.pins.selOutN <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign rdData = r.rdData;
  assign pinOut = r.pins;
  assign multiMasterError = r.mme;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstN);

  property p_sclkRest;
    r.fsm == S_IDLE |=> r.sclk == $past(r.mode.clockIdleLevelBit);
  endproperty
  a_sclkRest: assert property (p_sclkRest) else $error("clock left rest level");

  property p_offQuiet;
    !r.mode.enable |-> r.fsm == S_IDLE && !r.pins.sclkOe ##1 !baudTick;
  endproperty
  a_offQuiet: assert property (p_offQuiet) else $error("disabled port active");

  property p_misoIn;
    r.mode.master |-> !r.pins.misoOe;
  endproperty
  a_misoIn: assert property (p_misoIn) else $error("master drives miso");

  property p_mosiIn;
    !r.mode.master |-> !r.pins.mosiOe && !r.pins.sclkOe;
  endproperty
  a_mosiIn: assert property (p_mosiIn) else $error("slave drives mosi");

  property p_mme;
    r.mode.enable && r.mode.master && !pinIn.slaveSelectInputN
      |=> r.mme && r.fsm == S_IDLE && !r.pins.sclkOe && !r.pins.mosiOe;
  endproperty
  a_mme: assert property (p_mme) else $error("select low not flagged");

  property p_slaveWait;
    r.mode.enable && !r.mode.master && pinIn.slaveSelectInputN && !bus.wrStb
      |=> r.fsm == S_IDLE;
  endproperty
  a_slaveWait: assert property (p_slaveWait) else $error("unselected slave shifts");

  property p_tickOnly;
    r.mode.master && r.fsm == S_SHIFT && $past(r.fsm) == S_SHIFT && $changed(r.sclk)
      |-> $past(baudTick);
  endproperty
  a_tickOnly: assert property (p_tickOnly) else $error("clock moved without tick");

  property p_openDrain;
    r.mode.openDrain |-> !(r.pins.mosiOe && r.pins.mosiO) && !(r.pins.sclkOe && r.pins.sclkO);
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("open drain drives high");

  property p_txBuf;
    bus.wrStb && bus.addr == OFS_TX && !r.txFull |=> r.txFull;
  endproperty
  a_txBuf: assert property (p_txBuf) else $error("transmit holding not filled");

  c_masterChar: cover property (r.mode.master && charDone);
  c_slaveChar: cover property (!r.mode.master && charDone);
  c_backToBack: cover property (charDone ##1 r.fsm == S_SHIFT);
  c_mme: cover property ($rose(r.mme));
endmodule

/* File: tb/spi_far_slave.sv */
// Behavioural serial slave device facing the port in master mode
`timescale 1ns/1ps
module spi_far_slave (
  input wire logic sclk,
  input wire logic selN,
  input wire logic mosi,
  input wire logic [15:0] txWord,
  input wire logic [4:0] len,
  output logic miso,
  output logic [15:0] rxWord
);
  int idx;
  initial begin
    miso = 1'b0;
    rxWord = 16'h0000;
    idx = 0;
  end
  // Most significant bit of the character is presented first
  always @(negedge selN) begin
    idx = len - 1;
    miso = txWord[idx];
    rxWord = 16'h0000;
  end
  // Idle-low clock, phase 0: capture on rising, next bit on falling
  always @(posedge sclk) begin
    if (!selN) rxWord = {rxWord[14:0], mosi};
  end
  always @(negedge sclk) begin
    if (!selN && idx > 0) begin
      idx = idx - 1;
      miso = txWord[idx];
    end
  end
  // Released line: show the inverse so a stale value never matches
  always @(posedge selN) miso = ~miso;
endmodule

/* File: tb/spi_shift_core_test.sv */
// Self-checking bench of the serial shift port core in master mode
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module spi_shift_core_test;
  import spi_shift_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  bus_req_t bus = '0;
  logic [15:0] rdData;
  pin_in_t pinIn;
  pin_out_t pinOut;
  logic baudSrc = 1'b0;
  logic selInN = 1'b1;
  logic multiMasterError;
  logic sclkW, mosiW, misoW, slvMiso;
  logic [15:0] slvTx = 16'h0000;
  logic [15:0] slvRx;
  logic [4:0] slvLen = 5'h08;
  logic [31:0] seed = 32'h74665041;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [15:0] expQ[$];

  always #12.5 sys_clk = ~sys_clk;
  // Baud source rises every second system cycle
  always @(posedge sys_clk) baudSrc <= ~baudSrc;

  // Pull-ups hold released clock and mosi lines high; released miso follows the far slave
  assign sclkW = pinOut.sclkOe ? pinOut.sclkO : 1'b1;
  assign mosiW = pinOut.mosiOe ? pinOut.mosiO : 1'b1;
  assign misoW = pinOut.misoOe ? pinOut.misoO : slvMiso;
  assign pinIn = {sclkW, mosiW, misoW, selInN};

  spi_shift_core DUT (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .rdData(rdData),
    .pinIn(pinIn), .pinOut(pinOut), .baudSourceClock(baudSrc),
    .multiMasterError(multiMasterError));
  spi_far_slave FAR (.sclk(sclkW), .selN(pinOut.selOutN), .mosi(mosiW), .txWord(slvTx),
    .len(slvLen), .miso(slvMiso), .rxWord(slvRx));

  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wrData <= d;
    bus.wrStb <= 1'b1;
    @(posedge sys_clk);
    bus.wrStb <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rdStb <= 1'b1;
    @(posedge sys_clk);
    bus.rdStb <= 1'b0;
    @(negedge sys_clk);
    d = rdData;
  endtask

  task automatic xfer(input int len, input logic loop, input logic ph);
    logic [15:0] w, mask, got;
    logic [31:0] r;
    mode_t m;
    int i;
    mask = 16'hFFFF >> (16 - len);
    w = nxt();
    r = nxt();
    slvTx = r[15:0];
    slvLen = len[4:0];
    m = '0;
    m.master = 1'b1;
    m.enable = 1'b1;
    m.loopBack = loop;
    m.clockPhase = ph;
    m.openDrain = ph;
    m.charLen = 4'(len - 1);
    wr(OFS_DIV, {14'h0000, r[17:16]});
    wr(OFS_MODE, m);
    wr(OFS_TX, w);
    expQ.push_back(loop ? (w & mask) : (r[15:0] & mask));
    for (i = 0; i < 300; i++) begin
      rd(OFS_STAT, got);
      if (got[ST_RXFULL] === 1'b1) break;
    end
    rd(OFS_RX, got);
    `CHK(got & mask, expQ.pop_front())
    if (!loop) `CHK(slvRx & mask, w & mask)
    $display("test transfer len %0d loop %0d phase %0d done", len, loop, ph);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(25 * 60000);
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic [15:0] d;
    mode_t m;
    int k;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(OFS_MODE, d);
    `CHK(d, MODE_RST)
    rd(OFS_DIV, d);
    `CHK(d, {8'h00, DIV_RST})
    rd(3'h6, d);
    `CHK(d, 16'h0000)
    `CHK(pinOut.sclkOe, 1'b0)
    `CHK(pinOut.misoOe, 1'b0)
    $display("test reset done");
    m = '0;
    m.master = 1'b1;
    m.enable = 1'b1;
    m.charLen = 4'h7;
    m.clockIdleLevelBit = 1'b1;
    wr(OFS_MODE, m);
    repeat (12) @(posedge sys_clk);
    `CHK(pinOut.sclkO, 1'b1)
    `CHK(pinOut.mosiOe, 1'b1)
    `CHK(pinOut.misoOe, 1'b0)
    m.clockIdleLevelBit = 1'b0;
    wr(OFS_MODE, m);
    repeat (12) @(posedge sys_clk);
    `CHK(pinOut.sclkO, 1'b0)
    $display("test idle level done");
    xfer(4, 1'b0, 1'b0);
    xfer(16, 1'b0, 1'b0);
    xfer(8, 1'b0, 1'b0);
    for (k = 0; k < 4; k++) xfer(4 + (nxt() % 13), 1'b0, 1'b0);
    xfer(12, 1'b1, 1'b0);
    xfer(12, 1'b1, 1'b1);
    wr(OFS_MODE, m);
    selInN <= 1'b0;
    repeat (6) @(posedge sys_clk);
    `CHK(multiMasterError, 1'b1)
    `CHK({pinOut.sclkOe, pinOut.mosiOe, pinOut.misoOe}, 3'b000)
    rd(OFS_STAT, d);
    `CHK(d[ST_MME], 1'b1)
    selInN <= 1'b1;
    wr(OFS_MODE, MODE_RST);
    wr(OFS_STAT, 16'h0010);
    repeat (2) @(posedge sys_clk);
    `CHK(multiMasterError, 1'b0)
    $display("test multi master done");
    complete_run();
  end
endmodule
